// file: hdl/ancillary_bank.v
// Small memory of implementation-defined ancillary state registers 16..31.
// Assumes the caller has already checked privilege and the register number.
`timescale 1ns/1ps

module ancillary_bank #(
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire core_clk,
  input wire sys_rst,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [31:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [31:0] rd_data
);

  // ---------------------------------------------------------------------------
  // Storage.
  // ---------------------------------------------------------------------------
  reg [31:0] mem_q [0:DEPTH-1]; // One word per ancillary register.

  // Each entry clears on reset so reads never return stale data.
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1)
    begin : g_entry
      always @(posedge core_clk)
      begin
        if (sys_rst)
        begin
          mem_q[gi] <= 32'h00000000;
        end
        else if (wr_en && (wr_addr == gi))
        begin
          mem_q[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // Registered read port.
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rd_data <= 32'h00000000;
    end
    else
    begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule

// file: hdl/iu_control_status_regs.v
// Integer unit control and status registers: invalid mask, trap base,
// multiply high word, instruction address pair, ancillary registers, queue.
// Assumes the core issues at most one request per cycle and honours trap_req.
//
// Overview of operation
// - One mask bit per implemented window.
// - Save/restore/return trap if target masked.
// - Unimplemented mask bits read zero, writes dropped.
// - Mask register is thirty-two bits wide.
// - Mask reached only by privileged read/write.
// - Trap base: base, code, zero fields.
// - Base field loaded only by base write.
// - Hardware writes trap code on each trap.
// - Low four trap base bits read zero.
// - Multiply results load the high word.
// - Divides take dividend high from register.
// - High word readable and writable directly.
// - Current and next instruction address held.
// - Delay instruction runs unless annulled.
// - During delay slot next points target.
// - Trap entry hands both addresses out.
// - Call and jump-link read current address.
// - Ancillary numbers 1-15 reserved, 16-31 implemented.
// - Ancillary access privileged when register privileged.
// - Deferred queue reachable only when privileged.
// - Window index wraps on traps/saves/restores.
`timescale 1ns/1ps
`include "iu_csr_defines.vh"

module iu_control_status_regs #(
  parameter NWIN = 8,
  parameter [15:0] ANC_PRIV_MAP = 16'hffff,
  parameter QDEPTH = 2
) (
  input wire core_clk,
  input wire sys_rst,
  input wire supervisor,
  input wire acc_rd,
  input wire acc_wr,
  input wire [2:0] acc_sel,
  input wire [4:0] acc_anc_num,
  input wire [31:0] acc_wdata,
  output reg [31:0] acc_rdata,
  output reg acc_rvalid,
  input wire save_req,
  input wire restore_req,
  input wire return_from_trap_instr_req,
  input wire trap_in,
  input wire [7:0] trap_in_code,
  output reg trap_req,
  output reg [7:0] trap_code,
  output wire [31:0] trap_vector,
  output reg [31:0] saved_cur_addr,
  output reg [31:0] saved_next_addr,
  output reg saved_valid,
  output wire [4:0] window_index,
  input wire step_valid,
  input wire xfer_taken,
  input wire xfer_annul,
  input wire [31:0] xfer_target,
  output wire [31:0] cur_instr_addr,
  output wire [31:0] next_instr_addr,
  output wire [31:0] link_addr,
  input wire mul_valid,
  input wire [31:0] mul_hi_result,
  output wire [31:0] div_dividend_hi,
  input wire queue_push,
  input wire [31:0] queue_push_data
);

  // ---------------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------------
  reg [31:0] window_invalid_mask_q; // Invalid window mask.
  reg [31:0] window_invalid_mask_d;
  reg [19:0] trap_base_field_q; // Trap table base.
  reg [7:0] trap_code_field_q; // Code of the most recent trap.
  reg [31:0] mul_div_hi_word_q; // Multiply/divide high word.
  reg [31:0] cur_addr_q; // Current instruction address.
  reg [31:0] next_addr_q; // Next instruction address.
  reg annul_q; // Next fetched instruction is annulled.
  reg [31:0] queue_q [0:QDEPTH-1]; // Deferred trap queue entries.
  reg [31:0] qword_d;
  reg anc_rd_q; // Read data of this cycle comes from the bank.
  wire [31:0] anc_rdata;
  wire [4:0] dec_target;
  wire [4:0] inc_target;
  wire dec_invalid;
  wire inc_invalid;

  // Implemented-window mask: higher bits are forced to zero.
  localparam [31:0] IMPL_MASK = (NWIN >= 32) ? 32'hffffffff :
    ((32'h00000001 << NWIN) - 32'h00000001);

  // ---------------------------------------------------------------------------
  // Access qualification.
  // ---------------------------------------------------------------------------
  wire acc_any = acc_rd | acc_wr;
  wire anc_impl = (acc_anc_num >= `ANC_FIRST_IMPL);
  wire [3:0] anc_idx = acc_anc_num[3:0];
  wire anc_priv = ANC_PRIV_MAP[anc_idx];
  // Ancillary slots need supervisor mode only when marked privileged.
  wire need_priv = (acc_sel == `SEL_ANCILLARY) ? anc_priv :
    (acc_sel != `SEL_MUL_HI);
  wire priv_fault = acc_any && need_priv && !supervisor;
  wire bad_sel = acc_any && ((acc_sel == `SEL_ANCILLARY) && !anc_impl);
  wire wr_ok = acc_wr && !priv_fault && !bad_sel;
  wire rd_ok = acc_rd && !priv_fault && !bad_sel;

  // ---------------------------------------------------------------------------
  // Window moves: a trapping move leaves the index where it is.
  // ---------------------------------------------------------------------------
  wire save_trap = save_req && dec_invalid;
  wire rest_trap = (restore_req || return_from_trap_instr_req) && inc_invalid;
  wire win_dec = (save_req && !dec_invalid) || trap_in;
  wire win_inc = (restore_req || return_from_trap_instr_req) && !inc_invalid && !trap_in;

  window_ring #(
    .NWIN(NWIN),
    .IW(5)
  ) u_ring (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .dec_req(win_dec),
    .inc_req(win_inc),
    .mask(window_invalid_mask_q),
    .window_index(window_index),
    .dec_target(dec_target),
    .inc_target(inc_target),
    .dec_invalid(dec_invalid),
    .inc_invalid(inc_invalid)
  );

  ancillary_bank #(
    .DEPTH(`ANC_IMPL_COUNT),
    .AW(4)
  ) u_anc (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .wr_en(wr_ok && (acc_sel == `SEL_ANCILLARY)),
    .wr_addr(anc_idx),
    .wr_data(acc_wdata),
    .rd_addr(anc_idx),
    .rd_data(anc_rdata)
  );

  // ---------------------------------------------------------------------------
  // Combinational views.
  // ---------------------------------------------------------------------------
  assign trap_vector = {trap_base_field_q, trap_code_field_q, 4'h0};
  assign cur_instr_addr = cur_addr_q;
  assign next_instr_addr = next_addr_q;
  assign link_addr = cur_addr_q;
  assign div_dividend_hi = mul_div_hi_word_q;

  // Mask write keeps only implemented windows.
  always @*
  begin
    window_invalid_mask_d = window_invalid_mask_q;
    if (wr_ok && (acc_sel == `SEL_MASK))
    begin
      window_invalid_mask_d = acc_wdata & IMPL_MASK;
    end
  end

  // Queue read word, chosen by bit 0 of the number: entry 0 or the last entry.
  always @*
  begin
    qword_d = queue_q[0];
    if (acc_anc_num[0] && (QDEPTH > 1))
    begin
      qword_d = queue_q[QDEPTH-1];
    end
  end

  // ---------------------------------------------------------------------------
  // Control and status registers.
  // ---------------------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      window_invalid_mask_q <= `RESET_WORD;
      trap_base_field_q <= 20'h00000;
      trap_code_field_q <= 8'h00;
      mul_div_hi_word_q <= `RESET_WORD;
    end
    else
    begin
      window_invalid_mask_q <= window_invalid_mask_d;
      // Only the base write touches the base field; code bits are ignored.
      if (wr_ok && (acc_sel == `SEL_TRAP_BASE))
      begin
        trap_base_field_q <= acc_wdata[`TB_BASE_HI:`TB_BASE_LO];
      end
      // A trap's code wins over everything else in the same cycle.
      if (trap_in)
      begin
        trap_code_field_q <= trap_in_code;
      end
      else if (priv_fault)
      begin
        trap_code_field_q <= `TRAP_PRIV_INSTR;
      end
      else if (bad_sel)
      begin
        trap_code_field_q <= `TRAP_ILLEGAL_INSTR;
      end
      else if (save_trap)
      begin
        trap_code_field_q <= `TRAP_WIN_OVERFLOW;
      end
      else if (rest_trap)
      begin
        trap_code_field_q <= `TRAP_WIN_UNDERFLOW;
      end
      // Hardware multiply result wins over a direct write of the same cycle.
      if (mul_valid)
      begin
        mul_div_hi_word_q <= mul_hi_result;
      end
      else if (wr_ok && (acc_sel == `SEL_MUL_HI))
      begin
        mul_div_hi_word_q <= acc_wdata;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Instruction address pair with delayed transfers.
  // ---------------------------------------------------------------------------
  // The delay instruction takes the old next address; the target goes to next.
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cur_addr_q <= `RESET_WORD;
      next_addr_q <= `RESET_NEXT_ADDR;
      annul_q <= 1'b0;
    end
    else if (trap_in)
    begin
      cur_addr_q <= {trap_base_field_q, trap_in_code, 4'h0};
      next_addr_q <= {trap_base_field_q, trap_in_code, 4'h0} + `INSTR_STEP;
      annul_q <= 1'b0;
    end
    else if (step_valid)
    begin
      cur_addr_q <= next_addr_q;
      if (xfer_taken && !annul_q)
      begin
        next_addr_q <= xfer_target;
        annul_q <= xfer_annul;
      end
      else
      begin
        next_addr_q <= next_addr_q + `INSTR_STEP;
        annul_q <= 1'b0;
      end
    end
  end

  // Trap entry snapshot for the two local registers of the new window.
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      saved_cur_addr <= `RESET_WORD;
      saved_next_addr <= `RESET_WORD;
      saved_valid <= 1'b0;
    end
    else
    begin
      saved_valid <= trap_in;
      if (trap_in)
      begin
        saved_cur_addr <= cur_addr_q;
        saved_next_addr <= next_addr_q;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Deferred trap queue: a shift queue filled by the core.
  // ---------------------------------------------------------------------------
  genvar qi;
  generate
    for (qi = 0; qi < QDEPTH; qi = qi + 1)
    begin : g_queue
      always @(posedge core_clk)
      begin
        if (sys_rst)
        begin
          queue_q[qi] <= `RESET_WORD;
        end
        else if (wr_ok && (acc_sel == `SEL_DEFER_QUEUE))
        begin
          queue_q[qi] <= acc_wdata;
        end
        else if (queue_push)
        begin
          queue_q[qi] <= (qi == 0) ? queue_push_data : queue_q[(qi == 0) ? 0 : qi - 1];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Read path and trap request.
  // ---------------------------------------------------------------------------
  // Faults and window traps are reported one cycle after the request.
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      acc_rdata <= `RESET_WORD;
      acc_rvalid <= 1'b0;
      anc_rd_q <= 1'b0;
      trap_req <= 1'b0;
      trap_code <= 8'h00;
    end
    else
    begin
      trap_req <= priv_fault || bad_sel || save_trap || rest_trap;
      trap_code <= priv_fault ? `TRAP_PRIV_INSTR :
        (bad_sel ? `TRAP_ILLEGAL_INSTR :
        (save_trap ? `TRAP_WIN_OVERFLOW : `TRAP_WIN_UNDERFLOW));
      acc_rvalid <= rd_ok && (acc_sel != `SEL_ANCILLARY);
      anc_rd_q <= rd_ok && (acc_sel == `SEL_ANCILLARY);
      if (anc_rd_q)
      begin
        acc_rdata <= anc_rdata;
        acc_rvalid <= 1'b1;
      end
      else if (rd_ok)
      begin
        if (acc_sel == `SEL_MASK)
        begin
          acc_rdata <= window_invalid_mask_q;
        end
        else if (acc_sel == `SEL_TRAP_BASE)
        begin
          acc_rdata <= {trap_base_field_q, trap_code_field_q, 4'h0};
        end
        else if (acc_sel == `SEL_MUL_HI)
        begin
          acc_rdata <= mul_div_hi_word_q;
        end
        else if (acc_sel == `SEL_CUR_ADDR)
        begin
          acc_rdata <= cur_addr_q;
        end
        else if (acc_sel == `SEL_NEXT_ADDR)
        begin
          acc_rdata <= next_addr_q;
        end
        else if (acc_sel == `SEL_DEFER_QUEUE)
        begin
          acc_rdata <= qword_d;
        end
        else
        begin
          acc_rdata <= `RESET_WORD;
        end
      end
    end
  end

endmodule

// file: hdl/iu_csr_defines.vh
// Constants for the integer unit control and status register block.
// Assumes inclusion by bare name from the design files under hdl/.
`ifndef IU_CSR_DEFINES_VH
`define IU_CSR_DEFINES_VH

// -----------------------------------------------------------------------------
// Register selector codes on the privileged register access port.
// -----------------------------------------------------------------------------
`define SEL_MASK 3'h0
`define SEL_TRAP_BASE 3'h1
`define SEL_MUL_HI 3'h2
`define SEL_CUR_ADDR 3'h3
`define SEL_NEXT_ADDR 3'h4
`define SEL_ANCILLARY 3'h5
`define SEL_DEFER_QUEUE 3'h6

// -----------------------------------------------------------------------------
// Trap base register field layout.
// -----------------------------------------------------------------------------
`define TB_BASE_HI 31
`define TB_BASE_LO 12
`define TB_CODE_HI 11
`define TB_CODE_LO 4
`define TB_ZERO_HI 3

// -----------------------------------------------------------------------------
// Trap codes raised by this block, reset values and the instruction step.
// -----------------------------------------------------------------------------
`define TRAP_PRIV_INSTR 8'h03
`define TRAP_WIN_OVERFLOW 8'h05
`define TRAP_WIN_UNDERFLOW 8'h06
`define TRAP_ILLEGAL_INSTR 8'h02
`define RESET_WORD 32'h00000000
`define RESET_NEXT_ADDR 32'h00000004
`define INSTR_STEP 32'h00000004

// -----------------------------------------------------------------------------
// Ancillary register numbering.
// -----------------------------------------------------------------------------
`define ANC_FIRST_IMPL 5'h10
`define ANC_IMPL_COUNT 16

`endif

// file: hdl/window_ring.v
// Current window index counter with the invalid mask check for save and restore.
// Assumes one window move request per cycle from the core's decode stage.
`timescale 1ns/1ps

module window_ring #(
  parameter NWIN = 8,
  parameter IW = 5
) (
  input wire core_clk,
  input wire sys_rst,
  input wire dec_req,
  input wire inc_req,
  input wire [31:0] mask,
  output wire [IW-1:0] window_index,
  output wire [IW-1:0] dec_target,
  output wire [IW-1:0] inc_target,
  output wire dec_invalid,
  output wire inc_invalid
);

  // ---------------------------------------------------------------------------
  // Index register.
  // ---------------------------------------------------------------------------
  reg [IW-1:0] idx_q; // Current window index.
  reg [IW-1:0] idx_d; // Next index.

  localparam [IW-1:0] LAST = NWIN - 1;
  localparam [IW-1:0] ONE = 1;

  // Wrap explicitly, because the window count need not be a power of two.
  assign dec_target = (idx_q == {IW{1'b0}}) ? LAST : idx_q - ONE;
  assign inc_target = (idx_q == LAST) ? {IW{1'b0}} : idx_q + ONE;
  // The target window is flagged when its mask bit is set.
  assign dec_invalid = mask[dec_target];
  assign inc_invalid = mask[inc_target];
  assign window_index = idx_q;

  // Move the index; the caller suppresses requests that would trap.
  always @*
  begin
    idx_d = idx_q;
    if (dec_req)
    begin
      idx_d = dec_target;
    end
    else if (inc_req)
    begin
      idx_d = inc_target;
    end
  end

  // Index state.
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      idx_q <= {IW{1'b0}};
    end
    else
    begin
      idx_q <= idx_d;
    end
  end

endmodule

// file: testbench/iu_csr_chk.sv
// Assertion checker for the integer unit control and status register block.
// Assumes it is bound to the block top and sees only its ports.
`timescale 1ns/1ps
module iu_csr_chk #(
  parameter NWIN = 8
) (
  input wire core_clk,
  input wire sys_rst,
  input wire supervisor,
  input wire acc_rd,
  input wire acc_wr,
  input wire [2:0] acc_sel,
  input wire [31:0] acc_wdata,
  input wire [31:0] acc_rdata,
  input wire acc_rvalid,
  input wire save_req,
  input wire restore_req,
  input wire return_from_trap_instr_req,
  input wire trap_in,
  input wire [7:0] trap_in_code,
  input wire trap_req,
  input wire [7:0] trap_code,
  input wire [31:0] trap_vector,
  input wire [31:0] saved_cur_addr,
  input wire [31:0] saved_next_addr,
  input wire saved_valid,
  input wire [4:0] window_index,
  input wire step_valid,
  input wire [31:0] cur_instr_addr,
  input wire [31:0] next_instr_addr,
  input wire mul_valid,
  input wire [31:0] mul_hi_result,
  input wire [31:0] div_dividend_hi
);
  // ---------------------------------------------------------------
  // Common clocking and helper terms.
  // ---------------------------------------------------------------
  // All properties sample on the core clock and rest during reset.
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // A user-mode request that must be refused; multiply high word and ancillary are left out.
  wire user_bad = (acc_rd | acc_wr) & ~supervisor & (acc_sel != 3'h2) & (acc_sel != 3'h5);
  // A window move with nothing else competing in the same cycle.
  wire quiet = ~trap_in & ~acc_rd & ~acc_wr;

  property p_mask_rd;
    acc_rd && supervisor && acc_sel == 3'h0 |=> acc_rvalid && (acc_rdata >> NWIN) == 32'h0;
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask shows unbuilt windows");
  property p_user;
    user_bad |=> trap_req && trap_code == 8'h03 && !acc_rvalid;
  endproperty
  a_user: assert property (p_user) else $error("user access not refused");
  property p_tb_zero;
    trap_vector[3:0] == 4'h0;
  endproperty
  a_tb_zero: assert property (p_tb_zero) else $error("vector low bits not zero");
  property p_tb_wr;
    acc_wr && supervisor && acc_sel == 3'h1 |=> trap_vector[31:12] == $past(acc_wdata[31:12]);
  endproperty
  a_tb_wr: assert property (p_tb_wr) else $error("base field not loaded");
  property p_save;
    save_req && !restore_req && !return_from_trap_instr_req && quiet |=>
      (trap_req && trap_code == 8'h05 && $stable(window_index)) ||
      (!trap_req && window_index == ($past(window_index) + NWIN - 1) % NWIN);
  endproperty
  a_save: assert property (p_save) else $error("save move wrong");
  property p_restore;
    (restore_req || return_from_trap_instr_req) && !save_req && quiet |=>
      (trap_req && trap_code == 8'h06 && $stable(window_index)) ||
      (!trap_req && window_index == ($past(window_index) + 1) % NWIN);
  endproperty
  a_restore: assert property (p_restore) else $error("restore move wrong");
  property p_trap;
    trap_in |=> saved_valid && saved_cur_addr == $past(cur_instr_addr) &&
      saved_next_addr == $past(next_instr_addr) && trap_vector[11:4] == $past(trap_in_code) &&
      next_instr_addr == cur_instr_addr + 32'h4;
  endproperty
  a_trap: assert property (p_trap) else $error("trap entry state wrong");
  property p_step;
    step_valid && !trap_in |=> cur_instr_addr == $past(next_instr_addr);
  endproperty
  a_step: assert property (p_step) else $error("current address not advanced");
  property p_mul;
    mul_valid |=> div_dividend_hi == $past(mul_hi_result);
  endproperty
  a_mul: assert property (p_mul) else $error("high word not loaded");
endmodule

bind iu_control_status_regs iu_csr_chk #(.NWIN(NWIN)) iu_csr_chk_i (.core_clk, .sys_rst,
  .supervisor, .acc_rd, .acc_wr, .acc_sel, .acc_wdata, .acc_rdata, .acc_rvalid, .save_req,
  .restore_req, .return_from_trap_instr_req, .trap_in, .trap_in_code, .trap_req, .trap_code, .trap_vector,
  .saved_cur_addr, .saved_next_addr, .saved_valid, .window_index, .step_valid,
  .cur_instr_addr, .next_instr_addr, .mul_valid, .mul_hi_result, .div_dividend_hi);

// file: testbench/tb_top.sv
// Self-checking bench for the control and status register block.
// Assumes default parameters: eight windows, all ancillary registers privileged.
`timescale 1ns/1ps
module tb_top;
  reg core_clk, sys_rst, supervisor, acc_rd, acc_wr, save_req, restore_req, return_from_trap_instr_req;
  reg trap_in, step_valid, xfer_taken, xfer_annul, mul_valid, queue_push;
  reg [2:0] acc_sel;
  reg [4:0] acc_anc_num;
  reg [7:0] trap_in_code;
  reg [31:0] acc_wdata, xfer_target, mul_hi_result, queue_push_data;
  wire [31:0] acc_rdata, trap_vector, saved_cur_addr, saved_next_addr, cur_instr_addr;
  wire [31:0] next_instr_addr, link_addr, div_dividend_hi;
  wire acc_rvalid, trap_req, saved_valid;
  wire [7:0] trap_code;
  wire [4:0] window_index;
  // Reference model of the visible state.
  reg [31:0] cur_e, nxt_e, tba_e, y_e, r, q;
  reg [31:0] anc_e [0:15];
  reg [7:0] mask_e, tt_e;
  reg [4:0] wi_e;
  reg ann_e;
  integer seed, bad_count, check_count, i, k;

  iu_control_status_regs iu_control_status_regs_i (.core_clk, .sys_rst, .supervisor,
    .acc_rd, .acc_wr, .acc_sel, .acc_anc_num, .acc_wdata, .acc_rdata, .acc_rvalid,
    .save_req, .restore_req, .return_from_trap_instr_req, .trap_in, .trap_in_code, .trap_req, .trap_code,
    .trap_vector, .saved_cur_addr, .saved_next_addr, .saved_valid, .window_index,
    .step_valid, .xfer_taken, .xfer_annul, .xfer_target, .cur_instr_addr, .next_instr_addr,
    .link_addr, .mul_valid, .mul_hi_result, .div_dividend_hi, .queue_push, .queue_push_data);

  // 200 MHz core clock.
  always #2.5 core_clk = ~core_clk;

  // Compare one value and count it.
  task chk(input [8*8-1:0] name, input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("mismatch %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  // Print the verdict and stop.
  task wrap_up;
    begin
      if (bad_count == 0 && check_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  // Pass one edge; inputs then move 1 ns later so they never race it.
  task tick;
    begin
      @(posedge core_clk);
      #1;
    end
  endtask

  // Expected trap base word built from the model fields.
  function [31:0] tbr_e(input dummy);
    tbr_e = {tba_e[31:12], tt_e, 4'h0};
  endfunction

  // Expected read data for the plain registers.
  function [31:0] exp_rd(input [2:0] s);
    exp_rd = s == 3'h0 ? {24'h0, mask_e} : s == 3'h1 ? tbr_e(0) : s == 3'h2 ? y_e :
      s == 3'h3 ? cur_e : nxt_e;
  endfunction

  // One access pulse; an ancillary read needs one extra cycle.
  task acc(input rd, input [2:0] s, input [4:0] n, input [31:0] d);
    begin
      acc_rd = rd;
      acc_wr = ~rd;
      acc_sel = s;
      acc_anc_num = n;
      acc_wdata = d;
      tick;
      acc_rd = 0;
      acc_wr = 0;
      if (rd && s == 3'h5)
        tick;
    end
  endtask

  // Read and compare.
  task rd_chk(input [2:0] s, input [4:0] n, input [31:0] exp);
    begin
      acc(1'b1, s, n, 32'h0);
      chk("rvalid", acc_rvalid, 1);
      chk("rdata", acc_rdata, exp);
    end
  endtask

  // Write one register, update the model, read it back.
  task wr_rd(input [2:0] s, input [31:0] d);
    begin
      acc(1'b0, s, 5'h0, d);
      if (s == 3'h0)
        mask_e = d[7:0];
      if (s == 3'h1)
        tba_e = d;
      if (s == 3'h2)
        y_e = d;
      rd_chk(s, 5'h0, exp_rd(s));
    end
  endtask

  // A request that must be refused with the given trap code.
  task deny(input rd, input [2:0] s, input [4:0] n, input [7:0] c);
    begin
      acc(rd, s, n, $random(seed));
      tt_e = c;
      chk("trapreq", trap_req, 1);
      chk("trapcode", trap_code, c);
      chk("rvalid", acc_rvalid, 0);
    end
  endtask

  // Compare the instruction address pair and link address.
  task look;
    begin
      chk("cur", cur_instr_addr, cur_e);
      chk("next", next_instr_addr, nxt_e);
      chk("link", link_addr, cur_e);
    end
  endtask

  // Save (0), restore (1) or return from trap (2).
  task win(input [1:0] kind);
    reg [4:0] t;
    begin
      save_req = kind == 2'h0;
      restore_req = kind == 2'h1;
      return_from_trap_instr_req = kind == 2'h2;
      tick;
      save_req = 0;
      restore_req = 0;
      return_from_trap_instr_req = 0;
      t = kind == 2'h0 ? (wi_e + 5'h7) & 5'h7 : (wi_e + 5'h1) & 5'h7;
      chk("wintrap", trap_req, mask_e[t]);
      if (mask_e[t])
      begin
        tt_e = kind == 2'h0 ? 8'h05 : 8'h06;
        chk("wincode", trap_code, tt_e);
      end
      else
        wi_e = t;
      chk("winidx", window_index, wi_e);
    end
  endtask

  // One retired instruction with optional delayed transfer.
  task step(input tk, input an, input [31:0] tg);
    begin
      step_valid = 1;
      xfer_taken = tk;
      xfer_annul = an;
      xfer_target = tg;
      tick;
      step_valid = 0;
      xfer_taken = 0;
      xfer_annul = 0;
      cur_e = nxt_e;
      nxt_e = (tk && !ann_e) ? tg : cur_e + 32'h4;
      ann_e = (tk && !ann_e) ? an : 1'b0;
      look;
    end
  endtask

  // Trap entry from the trap logic.
  task trap(input [7:0] c);
    begin
      trap_in = 1;
      trap_in_code = c;
      tick;
      trap_in = 0;
      chk("svalid", saved_valid, 1);
      chk("scur", saved_cur_addr, cur_e);
      chk("snext", saved_next_addr, nxt_e);
      tt_e = c;
      ann_e = 1'b0;
      wi_e = (wi_e + 5'h7) & 5'h7;
      cur_e = tbr_e(0);
      nxt_e = cur_e + 32'h4;
      chk("vector", trap_vector, tbr_e(0));
      chk("winidx", window_index, wi_e);
      look;
    end
  endtask

  // Hang guard: far beyond the expected run length.
  initial
  begin
    #100000;
    bad_count = bad_count + 1;
    wrap_up;
  end

  // Main sequence: directed corners, then random traffic.
  initial
  begin
    {core_clk, supervisor, acc_rd, acc_wr, save_req, restore_req, return_from_trap_instr_req} = 7'h20;
    {trap_in, step_valid, xfer_taken, xfer_annul, mul_valid, queue_push} = 6'h0;
    {acc_sel, acc_anc_num, trap_in_code} = 16'h0;
    {acc_wdata, xfer_target, mul_hi_result, queue_push_data} = 128'h0;
    {cur_e, nxt_e, tba_e, y_e, mask_e, tt_e, wi_e, ann_e} = 150'h0;
    cur_e = 32'h0;
    nxt_e = 32'h4;
    seed = 15;
    bad_count = 0;
    check_count = 0;
    sys_rst = 1;
    repeat (5) tick;
    sys_rst = 0;
    look;
    chk("vector", trap_vector, 32'h0);
    wr_rd(3'h0, 32'hffffffff);
    for (k = 0; k < 16; k = k + 1)
    begin
      anc_e[k] = $random(seed);
      acc(1'b0, 3'h5, 5'h10 + k, anc_e[k]);
    end
    for (k = 0; k < 16; k = k + 1)
      rd_chk(3'h5, 5'h10 + k, anc_e[k]);
    deny(1'b0, 3'h5, 5'h3, 8'h02);
    r = $random(seed);
    acc(1'b0, 3'h6, 5'h0, r);
    queue_push = 1;
    queue_push_data = $random(seed);
    tick;
    queue_push = 0;
    rd_chk(3'h6, 5'h0, queue_push_data);
    rd_chk(3'h6, 5'h1, r);
    supervisor = 0;
    wr_rd(3'h2, $random(seed));
    deny(1'b0, 3'h5, 5'h11, 8'h03);
    deny(1'b1, 3'h6, 5'h0, 8'h03);
    supervisor = 1;
    step(1'b1, 1'b1, 32'h100);
    step(1'b1, 1'b0, 32'h200);
    step(1'b0, 1'b0, 32'h0);
    wr_rd(3'h0, 32'h00000040);
    repeat (3) win(2'h0);
    for (i = 0; i < 400; i = i + 1)
    begin
      r = $random(seed);
      q = $random(seed);
      case (r[2:0])
        3'h0: wr_rd({1'b0, q[1] & ~q[0], q[0]}, $random(seed));
        3'h1, 3'h2: win({q[1] & ~q[0], q[0]});
        3'h3, 3'h4: step(q[0], 1'b0, q & 32'hfffffffc);
        3'h5: trap(q[7:0]);
        3'h6:
        begin
          mul_valid = 1;
          mul_hi_result = q;
          tick;
          mul_valid = 0;
          y_e = q;
          chk("divhi", div_dividend_hi, y_e);
        end
        default:
        begin
          rd_chk(3'h3 + q[0], 5'h0, exp_rd(3'h3 + q[0]));
          supervisor = 0;
          k = q[4:2] % 5;
          deny(q[5], k == 4 ? 3'h6 : (k == 2 ? 3'h3 : (k == 3 ? 3'h4 : k)), 5'h0, 8'h03);
          supervisor = 1;
        end
      endcase
    end
    wrap_up;
  end
endmodule
